// ==== src/fic_pkg.sv ====
// package of the fast interrupt controller status and control block:
// register offsets, field positions, unlock keys and the nesting states.
// assumes a 32-bit apb slave port with byte addresses in a 4 KiB window.
package fic_pkg;

	// ==========================================================
	// sizes
	localparam int unsigned NIRQ = 24;
	localparam int unsigned IRQ_BASE = 12;
	localparam int unsigned LOW_CNT = 20;
	localparam int unsigned HIGH_CNT = 4;
	localparam int unsigned IDX_W = 5;
	localparam int unsigned PRIO_W = 8;
	localparam int unsigned ID_W = 8;
	localparam int unsigned NCHAN = 4;
	localparam int unsigned ADDR_W = 12;

	// ==========================================================
	// register byte offsets
	localparam logic [11:0] OFS_EN_STATE_LO = 12'h000;
	localparam logic [11:0] OFS_EN_STATE_HI = 12'h004;
	localparam logic [11:0] OFS_PEND_STATE_LO = 12'h020;
	localparam logic [11:0] OFS_PEND_STATE_HI = 12'h024;
	localparam logic [11:0] OFS_THRESHOLD = 12'h040;
	localparam logic [11:0] OFS_KEYED_CFG = 12'h048;
	localparam logic [11:0] OFS_GLOBAL = 12'h04c;
	localparam logic [11:0] OFS_FAST_IDS = 12'h050;
	localparam logic [11:0] OFS_FAST_FAST_CHAN0_HANDLER_ADDR = 12'h060;
	localparam logic [11:0] OFS_FAST_ADDR1 = 12'h064;
	localparam logic [11:0] OFS_FAST_ADDR2 = 12'h068;
	localparam logic [11:0] OFS_FAST_ADDR3 = 12'h06c;
	localparam logic [11:0] OFS_EN_SET_LO = 12'h100;
	localparam logic [11:0] OFS_EN_SET_HI = 12'h104;
	localparam logic [11:0] OFS_EN_CLR_LO = 12'h180;
	localparam logic [11:0] OFS_EN_CLR_HI = 12'h184;
	localparam logic [11:0] OFS_PEND_SET_LO = 12'h200;
	localparam logic [11:0] OFS_PEND_SET_HI = 12'h204;
	localparam logic [11:0] OFS_PEND_CLR_LO = 12'h280;
	localparam logic [11:0] OFS_PEND_CLR_HI = 12'h284;
	localparam logic [11:0] OFS_ACT_STATE_LO = 12'h300;
	localparam logic [11:0] OFS_ACT_STATE_HI = 12'h304;

	// ==========================================================
	// fields and keys
	localparam int unsigned KEY_LSB = 16;
	localparam int unsigned SYSRST_BIT = 7;
	localparam int unsigned GST_PEND_BIT = 9;
	localparam int unsigned GST_ACT_BIT = 8;
	localparam int unsigned FAST_ON_BIT = 0;
	localparam logic [7:0] THR_MASK = 8'hf0;
	localparam logic [15:0] KEY_A = 16'hfa05;
	localparam logic [15:0] KEY_B = 16'hbcaf;
	localparam logic [15:0] KEY_RESET = 16'hbeef;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// nesting state doubles as the nesting field value
	typedef enum logic [1:0] {
		FIC_NEST_IDLE = 2'b00,
		FIC_NEST_L1 = 2'b01,
		FIC_NEST_L2 = 2'b11
	} fic_nest_e;

endpackage : fic_pkg

// ==== src/fic_status_ctrl.sv ====
// status and control part of a vectored interrupt controller: enable,
// pending and active state of interrupts 12 to 35, threshold, keyed reset,
// global state, nesting and four fast channels, reached over apb.
// assumes request sources and the core run on pclk; priorities come from
// the priority array outside this block.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module fic_status_ctrl (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [fic_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt sources and priorities
	input wire logic [fic_pkg::NIRQ-1:0] irq_src,
	input wire logic [fic_pkg::NIRQ*fic_pkg::PRIO_W-1:0] irq_prio,
	// core side
	output logic irq_offer,
	output logic [fic_pkg::ID_W-1:0] irq_offer_num,
	output logic irq_fast,
	output logic [31:0] irq_fast_addr,
	input wire logic core_take,
	input wire logic core_return,
	// state towards the rest of the controller
	output logic [fic_pkg::NIRQ-1:0] irq_enabled_state,
	output logic [fic_pkg::NIRQ-1:0] irq_pending_state,
	output logic [fic_pkg::NIRQ-1:0] irq_active_state,
	output logic any_pending_flag,
	output logic any_active_flag,
	output logic [1:0] nesting_level,
	output logic system_reset_request
);

	// ==========================================================
	// helpers
	function automatic logic [fic_pkg::NIRQ-1:0] from_low(input logic [31:0] w);
		logic [fic_pkg::NIRQ-1:0] r;
		r = '0;
		r[fic_pkg::LOW_CNT-1:0] = w[31:fic_pkg::IRQ_BASE];
		return r;
	endfunction : from_low

	function automatic logic [fic_pkg::NIRQ-1:0] from_high(input logic [31:0] w);
		logic [fic_pkg::NIRQ-1:0] r;
		r = '0;
		r[fic_pkg::NIRQ-1:fic_pkg::LOW_CNT] = w[fic_pkg::HIGH_CNT-1:0];
		return r;
	endfunction : from_high

	// low bits stay zero: fixed exceptions have no control here
	function automatic logic [31:0] to_low(input logic [fic_pkg::NIRQ-1:0] v);
		return {v[fic_pkg::LOW_CNT-1:0], {fic_pkg::IRQ_BASE{1'b0}}};
	endfunction : to_low

	function automatic logic [31:0] to_high(input logic [fic_pkg::NIRQ-1:0] v);
		return {{(32 - fic_pkg::HIGH_CNT){1'b0}}, v[fic_pkg::NIRQ-1:fic_pkg::LOW_CNT]};
	endfunction : to_high

	function automatic logic [fic_pkg::PRIO_W-1:0] prio_of(input logic [fic_pkg::NIRQ*fic_pkg::PRIO_W-1:0] p,
			input int unsigned i);
		return p[i*fic_pkg::PRIO_W +: fic_pkg::PRIO_W];
	endfunction : prio_of

	// ==========================================================
	// state
	logic [fic_pkg::NIRQ-1:0] en;
	logic [fic_pkg::NIRQ-1:0] pend;
	logic [fic_pkg::NIRQ-1:0] act;
	logic [7:0] thr;
	logic [fic_pkg::ID_W-1:0] chan_num [fic_pkg::NCHAN];
	logic [30:0] chan_addr [fic_pkg::NCHAN];
	logic [fic_pkg::NCHAN-1:0] chan_on;
	logic sys_rst;
	logic [31:0] rdata;
	logic rerr;
	fic_pkg::fic_nest_e nest;
	logic [fic_pkg::IDX_W-1:0] top_idx;
	logic [fic_pkg::IDX_W-1:0] under_idx;
	logic [fic_pkg::PRIO_W-1:0] top_prio;
	logic [fic_pkg::PRIO_W-1:0] under_prio;
	logic offer;
	logic [fic_pkg::IDX_W-1:0] offer_idx;
	logic [fic_pkg::PRIO_W-1:0] offer_prio;
	logic fast;
	logic [31:0] fast_addr;

	logic [fic_pkg::NIRQ-1:0] next_en;
	logic [fic_pkg::NIRQ-1:0] next_pend;
	logic [fic_pkg::NIRQ-1:0] next_act;
	logic [7:0] next_thr;
	logic [fic_pkg::ID_W-1:0] next_chan_num [fic_pkg::NCHAN];
	logic [30:0] next_chan_addr [fic_pkg::NCHAN];
	logic [fic_pkg::NCHAN-1:0] next_chan_on;
	logic next_sys_rst;
	logic [31:0] next_rdata;
	logic next_rerr;
	fic_pkg::fic_nest_e next_nest;
	logic [fic_pkg::IDX_W-1:0] next_top_idx;
	logic [fic_pkg::IDX_W-1:0] next_under_idx;
	logic [fic_pkg::PRIO_W-1:0] next_top_prio;
	logic [fic_pkg::PRIO_W-1:0] next_under_prio;
	logic next_offer;
	logic [fic_pkg::IDX_W-1:0] next_offer_idx;
	logic [fic_pkg::PRIO_W-1:0] next_offer_prio;
	logic next_fast;
	logic [31:0] next_fast_addr;

	logic wr;
	logic rd_setup;
	logic [fic_pkg::NIRQ-1:0] ready_vec;
	logic cand_hit;
	logic [fic_pkg::IDX_W-1:0] cand_idx;
	logic [fic_pkg::PRIO_W-1:0] cand_prio;
	logic [fic_pkg::ID_W-1:0] cand_num;
	logic take;

	// ==========================================================
	// apb handshake: zero wait, data prepared in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & rerr;
	assign prdata = rdata;
	assign wr = psel & penable & pwrite & ~rerr;
	assign rd_setup = psel & ~penable;

	// ==========================================================
	// register read, decode and write effects
	always_comb begin
		next_rdata = rdata;
		next_rerr = rerr;
		next_en = en;
		next_thr = thr;
		next_chan_num = chan_num;
		next_chan_addr = chan_addr;
		next_chan_on = chan_on;
		next_sys_rst = 1'b0;
		if (rd_setup) begin
			next_rdata = fic_pkg::RST_WORD;
			next_rerr = 1'b0;
			case (paddr)
				fic_pkg::OFS_EN_STATE_LO: next_rdata = to_low(en);
				fic_pkg::OFS_EN_STATE_HI: next_rdata = to_high(en);
				fic_pkg::OFS_PEND_STATE_LO: next_rdata = to_low(pend);
				fic_pkg::OFS_PEND_STATE_HI: next_rdata = to_high(pend);
				fic_pkg::OFS_ACT_STATE_LO: next_rdata = to_low(act);
				fic_pkg::OFS_ACT_STATE_HI: next_rdata = to_high(act);
				fic_pkg::OFS_THRESHOLD: next_rdata = {24'h00_0000, thr};
				fic_pkg::OFS_KEYED_CFG: next_rdata = fic_pkg::RST_WORD;
				fic_pkg::OFS_GLOBAL: begin
					next_rdata = fic_pkg::RST_WORD;
					next_rdata[fic_pkg::GST_PEND_BIT] = |pend;
					next_rdata[fic_pkg::GST_ACT_BIT] = |act;
					next_rdata[1:0] = nest;
				end
				fic_pkg::OFS_FAST_IDS: next_rdata = {chan_num[3], chan_num[2], chan_num[1], chan_num[0]};
				fic_pkg::OFS_FAST_FAST_CHAN0_HANDLER_ADDR: next_rdata = {chan_addr[0], chan_on[0]};
				fic_pkg::OFS_FAST_ADDR1: next_rdata = {chan_addr[1], chan_on[1]};
				fic_pkg::OFS_FAST_ADDR2: next_rdata = {chan_addr[2], chan_on[2]};
				fic_pkg::OFS_FAST_ADDR3: next_rdata = {chan_addr[3], chan_on[3]};
				// write-only set and clear registers read as zero
				fic_pkg::OFS_EN_SET_LO, fic_pkg::OFS_EN_SET_HI,
				fic_pkg::OFS_EN_CLR_LO, fic_pkg::OFS_EN_CLR_HI,
				fic_pkg::OFS_PEND_SET_LO, fic_pkg::OFS_PEND_SET_HI,
				fic_pkg::OFS_PEND_CLR_LO, fic_pkg::OFS_PEND_CLR_HI: next_rdata = fic_pkg::RST_WORD;
				default: next_rerr = 1'b1;
			endcase
		end
		if (wr) begin
			case (paddr)
				fic_pkg::OFS_EN_SET_LO: next_en = en | from_low(pwdata);
				fic_pkg::OFS_EN_SET_HI: next_en = en | from_high(pwdata);
				fic_pkg::OFS_EN_CLR_LO: next_en = en & ~from_low(pwdata);
				fic_pkg::OFS_EN_CLR_HI: next_en = en & ~from_high(pwdata);
				fic_pkg::OFS_THRESHOLD: next_thr = pwdata[7:0] & fic_pkg::THR_MASK;
				fic_pkg::OFS_KEYED_CFG: begin
					// the reset bit acts only together with its own key
					if (pwdata[31:fic_pkg::KEY_LSB] == fic_pkg::KEY_RESET && pwdata[fic_pkg::SYSRST_BIT]) begin
						next_sys_rst = 1'b1;
					end
				end
				fic_pkg::OFS_FAST_IDS: begin
					next_chan_num[0] = pwdata[7:0];
					next_chan_num[1] = pwdata[15:8];
					next_chan_num[2] = pwdata[23:16];
					next_chan_num[3] = pwdata[31:24];
				end
				fic_pkg::OFS_FAST_FAST_CHAN0_HANDLER_ADDR, fic_pkg::OFS_FAST_ADDR1,
				fic_pkg::OFS_FAST_ADDR2, fic_pkg::OFS_FAST_ADDR3: begin
					next_chan_addr[paddr[3:2]] = pwdata[31:1];
					next_chan_on[paddr[3:2]] = pwdata[fic_pkg::FAST_ON_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= '0;
			rerr <= 1'b0;
			en <= '0;
			thr <= '0;
			chan_num <= '{default: '0};
			chan_addr <= '{default: '0};
			chan_on <= '0;
			sys_rst <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rerr <= next_rerr;
			en <= next_en;
			thr <= next_thr;
			chan_num <= next_chan_num;
			chan_addr <= next_chan_addr;
			chan_on <= next_chan_on;
			sys_rst <= next_sys_rst;
		end
	end

	// ==========================================================
	// arbitration: lowest priority value wins, ties to the lower number
	always_comb begin
		ready_vec = '0;
		cand_hit = 1'b0;
		cand_idx = '0;
		cand_prio = '1;
		for (int unsigned i = 0; i < fic_pkg::NIRQ; i++) begin
			// threshold zero leaves everything eligible
			ready_vec[i] = pend[i] & en[i] & ~act[i] &
				((thr == 8'h00) || (prio_of(irq_prio, i) >= thr));
			if (ready_vec[i] && (!cand_hit || prio_of(irq_prio, i) < cand_prio)) begin
				cand_hit = 1'b1;
				cand_idx = fic_pkg::IDX_W'(i);
				cand_prio = prio_of(irq_prio, i);
			end
		end
		cand_num = fic_pkg::ID_W'(cand_idx) + fic_pkg::ID_W'(fic_pkg::IRQ_BASE);
	end

	// ==========================================================
	// offer to the core, registered; fast channel lookup rides along
	always_comb begin
		next_offer = 1'b0;
		next_offer_idx = cand_idx;
		next_offer_prio = cand_prio;
		next_fast = 1'b0;
		next_fast_addr = '0;
		// at most two levels; a second level needs strictly higher urgency
		case (nest)
			fic_pkg::FIC_NEST_IDLE: next_offer = cand_hit;
			fic_pkg::FIC_NEST_L1: next_offer = cand_hit && (cand_prio < top_prio);
			default: next_offer = 1'b0;
		endcase
		// the cycle after a take the old offer is stale, so drop it once
		if (take || core_return) begin
			next_offer = 1'b0;
		end
		for (int unsigned c = 0; c < fic_pkg::NCHAN; c++) begin
			if (next_offer && chan_on[c] && chan_num[c] == cand_num && !next_fast) begin
				next_fast = 1'b1;
				next_fast_addr = {chan_addr[c], 1'b0};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offer <= 1'b0;
			offer_idx <= '0;
			offer_prio <= '0;
			fast <= 1'b0;
			fast_addr <= '0;
		end else begin
			offer <= next_offer;
			offer_idx <= next_offer_idx;
			offer_prio <= next_offer_prio;
			fast <= next_fast;
			fast_addr <= next_fast_addr;
		end
	end

	// ==========================================================
	// pending, active and nesting
	// a return in the same cycle as a take wins; the take is ignored
	assign take = core_take & offer & ~core_return;

	always_comb begin
		next_pend = pend;
		next_act = act;
		next_nest = nest;
		next_top_idx = top_idx;
		next_under_idx = under_idx;
		next_top_prio = top_prio;
		next_under_prio = under_prio;
		if (wr && paddr == fic_pkg::OFS_PEND_CLR_LO) begin
			next_pend = next_pend & ~from_low(pwdata);
		end
		if (wr && paddr == fic_pkg::OFS_PEND_CLR_HI) begin
			next_pend = next_pend & ~from_high(pwdata);
		end
		if (take) begin
			next_pend[offer_idx] = 1'b0;
			next_act[offer_idx] = 1'b1;
		end
		if (wr && paddr == fic_pkg::OFS_PEND_SET_LO) begin
			next_pend = next_pend | from_low(pwdata);
		end
		if (wr && paddr == fic_pkg::OFS_PEND_SET_HI) begin
			next_pend = next_pend | from_high(pwdata);
		end
		// a source request beats any clear in the same cycle
		next_pend = next_pend | irq_src;
		case (nest)
			fic_pkg::FIC_NEST_IDLE: begin
				if (take) begin
					next_nest = fic_pkg::FIC_NEST_L1;
					next_top_idx = offer_idx;
					next_top_prio = offer_prio;
				end
			end
			fic_pkg::FIC_NEST_L1: begin
				if (core_return) begin
					next_act[top_idx] = 1'b0;
					next_nest = fic_pkg::FIC_NEST_IDLE;
				end else if (take) begin
					next_nest = fic_pkg::FIC_NEST_L2;
					next_under_idx = top_idx;
					next_under_prio = top_prio;
					next_top_idx = offer_idx;
					next_top_prio = offer_prio;
				end
			end
			fic_pkg::FIC_NEST_L2: begin
				if (core_return) begin
					next_act[top_idx] = 1'b0;
					next_nest = fic_pkg::FIC_NEST_L1;
					next_top_idx = under_idx;
					next_top_prio = under_prio;
				end
			end
			default: next_nest = fic_pkg::FIC_NEST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= '0;
			act <= '0;
			nest <= fic_pkg::FIC_NEST_IDLE;
			top_idx <= '0;
			under_idx <= '0;
			top_prio <= '0;
			under_prio <= '0;
		end else begin
			pend <= next_pend;
			act <= next_act;
			nest <= next_nest;
			top_idx <= next_top_idx;
			under_idx <= next_under_idx;
			top_prio <= next_top_prio;
			under_prio <= next_under_prio;
		end
	end

	// ==========================================================
	// outputs
	assign irq_offer = offer;
	assign irq_offer_num = fic_pkg::ID_W'(offer_idx) + fic_pkg::ID_W'(fic_pkg::IRQ_BASE);
	assign irq_fast = fast;
	assign irq_fast_addr = fast_addr;
	assign irq_enabled_state = en;
	assign irq_pending_state = pend;
	assign irq_active_state = act;
	assign any_pending_flag = |pend;
	assign any_active_flag = |act;
	assign nesting_level = nest;
	assign system_reset_request = sys_rst;

endmodule : fic_status_ctrl

`default_nettype wire

// ==== test/fic_status_ctrl_monitor.sv ====
// checker of the status and control block, bound to its ports.
// assumes one pclk domain and presetn active low.
`timescale 1ns/1ps
`default_nettype none
module fic_status_ctrl_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic [fic_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// interrupt side
	input wire logic [fic_pkg::NIRQ-1:0] irq_src,
	input wire logic irq_offer,
	input wire logic [fic_pkg::ID_W-1:0] irq_offer_num,
	input wire logic irq_fast,
	input wire logic [31:0] irq_fast_addr,
	input wire logic core_take,
	input wire logic core_return,
	input wire logic [fic_pkg::NIRQ-1:0] irq_pending_state,
	input wire logic [fic_pkg::NIRQ-1:0] irq_active_state,
	input wire logic any_pending_flag,
	input wire logic any_active_flag,
	input wire logic [1:0] nesting_level,
	input wire logic system_reset_request
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd_acc;
	logic rst_wr;
	assign rd_acc = psel && penable && !pwrite;
	assign rst_wr = psel && penable && pwrite && paddr == fic_pkg::OFS_KEYED_CFG
		&& pwdata[31:16] == fic_pkg::KEY_RESET && pwdata[7];
	// ==========================================================
	// state flags
	any_pending_a: assert property (any_pending_flag == (|irq_pending_state))
		else $error("any pending flag wrong");
	any_active_a: assert property (any_active_flag == (|irq_active_state))
		else $error("any active flag wrong");
	nest_code_a: assert property (nesting_level != 2'b10)
		else $error("nesting code impossible");
	nest_idle_a: assert property ((nesting_level == 2'b00) == (irq_active_state == '0))
		else $error("nesting idle disagrees with active");
	take_active_a: assert property (irq_offer && core_take && !core_return
		|=> !irq_offer && irq_active_state[$past(irq_offer_num) - fic_pkg::IRQ_BASE])
		else $error("take did not mark active");
	src_pend_a: assert property (irq_src != '0
		|=> (irq_pending_state & $past(irq_src)) == $past(irq_src))
		else $error("source request not pending");
	// ==========================================================
	// keyed reset, fast address output and register reads
	rst_pulse_a: assert property (rst_wr |=> system_reset_request ##1 !system_reset_request)
		else $error("reset pulse wrong");
	rst_cause_a: assert property (system_reset_request |-> $past(rst_wr))
		else $error("reset without key");
	fast_addr_a: assert property (irq_fast |-> irq_offer && !irq_fast_addr[0])
		else $error("fast address bit 0 set");
	key_read_a: assert property (rd_acc && paddr == fic_pkg::OFS_KEYED_CFG |-> prdata == '0)
		else $error("key field reads nonzero");
	thr_read_a: assert property (rd_acc && paddr == fic_pkg::OFS_THRESHOLD
		|-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0)
		else $error("threshold low nibble nonzero");
	low_rsvd_a: assert property (rd_acc && (paddr == fic_pkg::OFS_EN_STATE_LO
		|| paddr == fic_pkg::OFS_PEND_STATE_LO) |-> prdata[11:0] == 12'h0)
		else $error("reserved low bits nonzero");
	high_rsvd_a: assert property (rd_acc && (paddr == fic_pkg::OFS_EN_STATE_HI
		|| paddr == fic_pkg::OFS_PEND_STATE_HI) |-> prdata[31:4] == 28'h0)
		else $error("high register upper bits nonzero");
endmodule : fic_status_ctrl_monitor
`default_nettype wire

// ==== test/fic_core_model.sv ====
// core model: takes an offered interrupt once the offer has stood DLY
// cycles and the bench allows it; returns on a bench request.
`timescale 1ns/1ps
`default_nettype none
module fic_core_model #(
	parameter int DLY = 2
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// controller side
	input wire logic irq_offer,
	output logic core_take,
	output logic core_return,
	// bench control
	input wire logic take_en,
	input wire logic ret_req
);
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic next_take;
	always_comb begin
		next_cnt = (irq_offer && !core_take) ? cnt + 4'h1 : 4'h0;
		// a slow core lets the offer stand before taking it
		next_take = take_en && irq_offer && !core_take && cnt >= 4'(DLY);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			core_take <= 1'b0;
			core_return <= 1'b0;
		end else begin
			cnt <= next_cnt;
			core_take <= next_take;
			// never return in the cycle of a take, the design would drop the take
			core_return <= ret_req && !next_take;
		end
	end
endmodule : fic_core_model
`default_nettype wire

// ==== test/fic_status_ctrl_tb.sv ====
// self-checking bench of the status and control block: apb master tasks,
// a core model and the bound checker. assumes a zero wait state slave.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module fic_status_ctrl_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [fic_pkg::ADDR_W-1:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, irq_fast_addr, q;
	logic pready, pslverr, err, irq_offer, irq_fast, core_take, core_return;
	logic any_pending_flag, any_active_flag, system_reset_request;
	logic [fic_pkg::NIRQ-1:0] irq_src = 24'h0;
	// interrupt 16 carries priority value 0x20, all others 0
	logic [fic_pkg::NIRQ*fic_pkg::PRIO_W-1:0] irq_prio = 192'h20 << 32;
	logic [7:0] irq_offer_num;
	logic [fic_pkg::NIRQ-1:0] irq_enabled_state, irq_pending_state, irq_active_state;
	logic [1:0] nesting_level;
	logic take_en = 1'b0;
	logic ret_req = 1'b0;
	logic [11:0] rst_ofs [8] = '{12'h000, 12'h004, 12'h020, 12'h024, 12'h040, 12'h04c, 12'h050, 12'h060};
	logic [7:0] thr [4] = '{8'hff, 8'h30, 8'h20, 8'h00};
	int n_fail = 0;
	int n_compared = 0;
	int n_rst = 0;
	always #25 pclk = ~pclk;
	always @(posedge pclk) if (system_reset_request === 1'b1) n_rst++;
	fic_status_ctrl uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .irq_src, .irq_prio, .irq_offer, .irq_offer_num, .irq_fast, .irq_fast_addr, .core_take,
		.core_return, .irq_enabled_state, .irq_pending_state, .irq_active_state, .any_pending_flag,
		.any_active_flag, .nesting_level, .system_reset_request);
	fic_core_model core (.pclk, .presetn, .irq_offer, .core_take, .core_return, .take_en, .ret_req);
	// ==========================================================
	// tasks
	task automatic summarize();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_fail++;
			summarize();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 32'h0);
		`CHK(nm, e, q)
	endtask : rd
	// ==========================================================
	// sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_ofs[i]) rd(rst_ofs[i], 32'h0, "reset value");
		wr(fic_pkg::OFS_EN_SET_LO, 32'hffff_ffff);
		wr(fic_pkg::OFS_EN_SET_HI, 32'hffff_ffff);
		rd(fic_pkg::OFS_EN_STATE_LO, 32'hffff_f000, "enable lo");
		rd(fic_pkg::OFS_EN_STATE_HI, 32'h0000_000f, "enable hi");
		wr(fic_pkg::OFS_EN_CLR_LO, 32'h0000_f000);
		wr(fic_pkg::OFS_EN_CLR_HI, 32'h0000_0001);
		rd(fic_pkg::OFS_EN_STATE_LO, 32'hffff_0000, "enable clear lo");
		rd(fic_pkg::OFS_EN_STATE_HI, 32'h0000_000e, "enable clear hi");
		`CHK("enable vector", 24'hef_fff0, irq_enabled_state)
		wr(fic_pkg::OFS_PEND_SET_LO, 32'h8000_0fff);
		wr(fic_pkg::OFS_PEND_SET_HI, 32'h0000_0002);
		rd(fic_pkg::OFS_PEND_STATE_LO, 32'h8000_0000, "pending lo");
		rd(fic_pkg::OFS_PEND_STATE_HI, 32'h0000_0002, "pending hi");
		rd(fic_pkg::OFS_GLOBAL, 32'h0000_0200, "global pending");
		wr(fic_pkg::OFS_PEND_CLR_LO, 32'h8000_0000);
		wr(fic_pkg::OFS_PEND_CLR_HI, 32'h0000_0002);
		rd(fic_pkg::OFS_PEND_STATE_LO, 32'h0, "pending clear");
		rd(fic_pkg::OFS_GLOBAL, 32'h0, "global idle");
		wr(fic_pkg::OFS_THRESHOLD, 32'hffff_ffff);
		rd(fic_pkg::OFS_THRESHOLD, 32'h0000_00f0, "threshold");
		@(posedge pclk);
		irq_src <= 24'h00_0010;
		@(posedge pclk);
		irq_src <= 24'h0;
		rd(fic_pkg::OFS_PEND_STATE_LO, 32'h0001_0000, "source pending");
		foreach (thr[i]) begin
			wr(fic_pkg::OFS_THRESHOLD, {24'h0, thr[i]});
			repeat (3) @(posedge pclk);
			`CHK("offer", thr[i] <= 8'h20, irq_offer)
		end
		`CHK("offer number", 8'd16, irq_offer_num)
		wr(fic_pkg::OFS_FAST_IDS, 32'h0302_0110);
		rd(fic_pkg::OFS_FAST_IDS, 32'h0302_0110, "fast ids");
		wr(fic_pkg::OFS_FAST_FAST_CHAN0_HANDLER_ADDR, 32'h0000_1234);
		repeat (3) @(posedge pclk);
		`CHK("fast off", 1'b0, irq_fast)
		wr(fic_pkg::OFS_FAST_FAST_CHAN0_HANDLER_ADDR, 32'h0000_1235);
		rd(fic_pkg::OFS_FAST_FAST_CHAN0_HANDLER_ADDR, 32'h0000_1235, "fast addr");
		repeat (2) @(posedge pclk);
		`CHK("fast on", 1'b1, irq_fast)
		`CHK("fast target", 32'h0000_1234, irq_fast_addr)
		take_en <= 1'b1;
		for (int n = 0; n < 20 && any_active_flag !== 1'b1; n++) @(posedge pclk);
		take_en <= 1'b0;
		if (any_active_flag !== 1'b1) begin
			n_fail++;
			summarize();
		end
		rd(fic_pkg::OFS_PEND_STATE_LO, 32'h0, "taken pending");
		rd(fic_pkg::OFS_ACT_STATE_LO, 32'h0001_0000, "active");
		rd(fic_pkg::OFS_GLOBAL, 32'h0000_0101, "global active");
		// a more urgent request nests a second level on top of interrupt 16
		wr(fic_pkg::OFS_PEND_SET_LO, 32'h0002_0000);
		take_en <= 1'b1;
		for (int n = 0; n < 20 && nesting_level !== 2'b11; n++) @(posedge pclk);
		take_en <= 1'b0;
		if (nesting_level !== 2'b11) begin
			n_fail++;
			summarize();
		end
		rd(fic_pkg::OFS_GLOBAL, 32'h0000_0103, "global nested");
		@(posedge pclk);
		ret_req <= 1'b1;
		// two returns pop both levels
		repeat (2) @(posedge pclk);
		ret_req <= 1'b0;
		rd(fic_pkg::OFS_GLOBAL, 32'h0, "global returned");
		wr(fic_pkg::OFS_KEYED_CFG, {fic_pkg::KEY_A, 16'h0080});
		wr(fic_pkg::OFS_KEYED_CFG, {fic_pkg::KEY_RESET, 16'h0000});
		`CHK("no reset", 0, n_rst)
		wr(fic_pkg::OFS_KEYED_CFG, {fic_pkg::KEY_RESET, 16'h0080});
		repeat (2) @(posedge pclk);
		`CHK("reset pulse", 1, n_rst)
		rd(fic_pkg::OFS_KEYED_CFG, 32'h0, "key read");
		rd(12'h3f0, 32'h0, "unmapped read");
		`CHK("unmapped error", 1'b1, err)
		summarize();
	end
endmodule : fic_status_ctrl_tb
bind fic_status_ctrl fic_status_ctrl_monitor mon (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
	.prdata, .irq_src, .irq_offer, .irq_offer_num, .irq_fast, .irq_fast_addr, .core_take, .core_return,
	.irq_pending_state, .irq_active_state, .any_pending_flag, .any_active_flag, .nesting_level,
	.system_reset_request);
`default_nettype wire
